/* core/dcf_pkg.sv */
/*
  Shared constants, pin bundles and state codes of the dual-clock FIFO flag block.
  Assumes a 25 MHz core clock that samples both slow FIFO clocks.
*/
package dcf_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CORE_CLK_PERIOD_NS       = 40;
  localparam int unsigned FULL_SKEW_MIN_NS         = 6;
  localparam int unsigned EMPTY_SKEW_MIN_NS        = 6;
  localparam int unsigned ALMOST_SKEW_MIN_NS       = 15;
  localparam int unsigned RETRANSMIT_RECOVERY_NS   = 90;

  function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned FULL_SKEW_CYC   = ns_to_cyc_up(FULL_SKEW_MIN_NS);
  localparam int unsigned EMPTY_SKEW_CYC  = ns_to_cyc_up(EMPTY_SKEW_MIN_NS);
  localparam int unsigned ALMOST_SKEW_CYC = ns_to_cyc_up(ALMOST_SKEW_MIN_NS);
  localparam int unsigned RTR_CYC         = ns_to_cyc_up(RETRANSMIT_RECOVERY_NS);

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned DATA_W     = 18;
  localparam int unsigned DEPTH_DEF  = 8192;
  localparam int unsigned OFFSET_W   = 16;
  localparam int unsigned IRQ_W      = 6;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [4:0] REG_CTRL       = 5'h00;
  localparam logic [4:0] REG_AE_OFFSET  = 5'h04;
  localparam logic [4:0] REG_AF_OFFSET  = 5'h08;
  localparam logic [4:0] REG_STATUS     = 5'h0C;
  localparam logic [4:0] REG_COUNT      = 5'h10;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h14;
  localparam logic [4:0] REG_IRQ_MASK   = 5'h18;

  localparam int unsigned CTRL_SYNC_BIT  = 0;
  localparam int unsigned ST_FULL_BIT    = 0;
  localparam int unsigned ST_EMPTY_BIT   = 1;
  localparam int unsigned ST_AF_BIT      = 2;
  localparam int unsigned ST_AE_BIT      = 3;
  localparam int unsigned ST_RECOV_BIT   = 4;
  localparam int unsigned IRQ_FULL_BIT   = 0;
  localparam int unsigned IRQ_EMPTY_BIT  = 1;
  localparam int unsigned IRQ_AF_BIT     = 2;
  localparam int unsigned IRQ_AE_BIT     = 3;
  localparam int unsigned IRQ_OVF_BIT    = 4;
  localparam int unsigned IRQ_UNF_BIT    = 5;

  localparam logic [31:0]         CTRL_RST      = 32'h0000_0000;
  localparam logic [OFFSET_W-1:0] AE_OFFSET_RST = 16'h0080;
  localparam logic [OFFSET_W-1:0] AF_OFFSET_RST = 16'h0080;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic              wclk;
    logic              wen_n;
    logic [DATA_W-1:0] data;
  } dcf_wr_pins_t;

  typedef struct packed {
    logic rclk;
    logic ren_n;
    logic oe_n;
    logic retransmit_n;
  } dcf_rd_pins_t;

  typedef struct packed {
    logic full_flag_n;
    logic empty_flag_n;
    logic almost_full_flag_n;
    logic almost_empty_flag_n;
  } dcf_flags_t;

  typedef enum logic [2:0] {
    RS_RUN     = 3'b001,
    RS_RELOAD  = 3'b010,
    RS_RECOVER = 3'b100
  } dcf_rtx_state_t;

endpackage

/* core/dcf_sync.sv */
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes the inputs change slowly against the core clock.
*/
`timescale 1ns/10ps
module dcf_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ****************************************
  // Two stages
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // dcf_sync

/* core/dcf_store.sv */
/*
  Flip-flop word storage, one write port and one combinational read port.
  Assumes the caller guards against writing a full buffer.
*/
`timescale 1ns/10ps
module dcf_store #(
  parameter int unsigned DEPTH = 8192,
  parameter int unsigned WIDTH = 18
) (
  // Clock
  input  wire logic                     core_clk,
  input  wire logic                     ce,
  // Write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule // dcf_store

/* core/dcf_fifo_core.sv */
/*
  Dual-clock FIFO with full, empty and programmable almost flags, retransmit,
  and an Avalon-MM register slave with interrupts.
  Assumes write and read clocks are slow pin levels sampled by core_clk.
*/
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module dcf_fifo_core
  import dcf_pkg::*;
#(
  parameter int unsigned DEPTH = 8192
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // Avalon-MM slave
  input  wire logic [4:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // FIFO pins
  input  wire dcf_pkg::dcf_wr_pins_t      wr_pins,
  input  wire dcf_pkg::dcf_rd_pins_t      rd_pins,
  output logic      [dcf_pkg::DATA_W-1:0] data_out,
  output logic                            data_oe,
  output dcf_pkg::dcf_flags_t             flags,
  // Interrupt
  output logic                            irq
);
  import dcf_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic spaced(input logic [3:0] since, input logic edge_now,
                                  input int unsigned cyc);
    return !edge_now && (32'(since) >= cyc);
  endfunction

  function automatic logic ae_hit(input logic [CW-1:0] cnt, input logic [OFFSET_W-1:0] n);
    return 32'(cnt) < 32'(n);
  endfunction

  function automatic logic af_hit(input logic [CW-1:0] cnt, input logic [OFFSET_W-1:0] m);
    return (32'(cnt) + 32'(m) + 32'd1) >= DEPTH;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Pin synchronisation and edges
  // ****************************************
  dcf_wr_pins_t   s_wr;
  dcf_rd_pins_t   s_rd;
  logic           wclk_q;
  logic           rclk_q;
  logic           rtx_q;
  logic           wr_edge;
  logic           rd_edge;
  logic           rtx_fall;

  dcf_sync #(
    .WIDTH($bits(dcf_wr_pins_t) + $bits(dcf_rd_pins_t))
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .async_in ({wr_pins, rd_pins}),
    .sync_out ({s_wr, s_rd})
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
      rtx_q  <= 1'b0;
    end else if (ce) begin
      wclk_q <= s_wr.wclk;
      rclk_q <= s_rd.rclk;
      rtx_q  <= s_rd.retransmit_n;
    end
  end

  // Clocks keep toggling in reset; edges only count after release
  assign wr_edge  = s_wr.wclk & ~wclk_q;
  assign rd_edge  = s_rd.rclk & ~rclk_q;
  assign rtx_fall = rtx_q & ~s_rd.retransmit_n;

  // ****************************************
  // Registers and state
  // ****************************************
  dcf_rtx_state_t        state;
  logic [1:0]            rtx_cnt;
  logic [AW-1:0]         wr_ptr;
  logic [AW-1:0]         rd_ptr;
  logic [CW-1:0]         count;
  logic [CW-1:0]         next_count;
  logic [3:0]            since_wr;
  logic [3:0]            since_rd;
  logic                  sync_sel;
  logic [OFFSET_W-1:0]   ae_offset;
  logic [OFFSET_W-1:0]   af_offset;
  logic [IRQ_W-1:0]      irq_status;
  logic [IRQ_W-1:0]      irq_mask;
  logic [IRQ_W-1:0]      irq_set;
  logic [IRQ_W-1:0]      irq_clr;
  dcf_flags_t            next_flags;
  logic [DATA_W-1:0]     rd_word;
  logic                  run;
  logic                  wr_try;
  logic                  rd_try;
  logic                  do_wr;
  logic                  do_rd;
  logic                  bus_wr;
  logic [4:0]            word_addr;
  logic [31:0]           next_rdata;
  logic [31:0]           wr_merged;
  logic [31:0]           wr_lanes;

  assign run    = (state == RS_RUN);
  assign wr_try = run && wr_edge && !s_wr.wen_n;
  assign rd_try = run && rd_edge && !s_rd.ren_n;
  assign do_wr  = wr_try && flags.full_flag_n;
  assign do_rd  = rd_try && flags.empty_flag_n;

  dcf_store #(
    .DEPTH (DEPTH),
    .WIDTH (DATA_W)
  ) u_store (
    .core_clk (core_clk),
    .ce       (ce),
    .wr_en    (do_wr),
    .wr_addr  (wr_ptr),
    .wr_data  (s_wr.data),
    .rd_addr  (rd_ptr),
    .rd_data  (rd_word)
  );

  always_comb begin
    next_count = count;
    if (do_wr && !do_rd) begin
      next_count = count + CW'(1);
    end else if (do_rd && !do_wr) begin
      next_count = count - CW'(1);
    end
  end

  // ****************************************
  // Pointers and count
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (state == RS_RELOAD) begin
        rd_ptr <= '0;
        count  <= (count == CW'(DEPTH)) ? CW'(DEPTH) : CW'(wr_ptr);
      end else begin
        if (do_rd) begin
          rd_ptr <= rd_ptr + AW'(1);
        end
        count <= next_count;
      end
    end
  end

  // ****************************************
  // Clock edge spacing
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_wr <= 4'hF;
      since_rd <= 4'hF;
    end else if (ce) begin
      if (wr_edge) begin
        since_wr <= 4'h1;
      end else if (since_wr != 4'hF) begin
        since_wr <= since_wr + 4'h1;
      end
      if (rd_edge) begin
        since_rd <= 4'h1;
      end else if (since_rd != 4'hF) begin
        since_rd <= since_rd + 4'h1;
      end
    end
  end

  // ****************************************
  // Retransmit sequencing
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state   <= RS_RUN;
      rtx_cnt <= '0;
    end else if (ce) begin
      case (state)
        RS_RUN: begin
          if (rtx_fall) begin
            state <= RS_RELOAD;
          end
        end
        RS_RELOAD: begin
          state   <= RS_RECOVER;
          rtx_cnt <= 2'(RTR_CYC - 1);
        end
        RS_RECOVER: begin
          if (rtx_cnt == '0) begin
            state <= RS_RUN;
          end else begin
            rtx_cnt <= rtx_cnt - 2'd1;
          end
        end
        default: begin
          state <= RS_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // Flag evaluation
  // ****************************************
  always_comb begin
    next_flags = flags;
    if (run) begin
      if (wr_edge) begin
        if (next_count == CW'(DEPTH)) begin
          next_flags.full_flag_n = 1'b0;
        end else if (spaced(since_rd, rd_edge, FULL_SKEW_CYC)) begin
          next_flags.full_flag_n = 1'b1;
        end
        if (sync_sel) begin
          if (af_hit(next_count, af_offset)) begin
            next_flags.almost_full_flag_n = 1'b0;
          end else if (spaced(since_rd, rd_edge, ALMOST_SKEW_CYC)) begin
            next_flags.almost_full_flag_n = 1'b1;
          end
        end
      end
      if (rd_edge) begin
        if (next_count == '0) begin
          next_flags.empty_flag_n = 1'b0;
        end else if (spaced(since_wr, wr_edge, EMPTY_SKEW_CYC)) begin
          next_flags.empty_flag_n = 1'b1;
        end
        if (sync_sel) begin
          if (ae_hit(next_count, ae_offset)) begin
            next_flags.almost_empty_flag_n = 1'b0;
          end else if (spaced(since_wr, wr_edge, ALMOST_SKEW_CYC)) begin
            next_flags.almost_empty_flag_n = 1'b1;
          end
        end
      end
    end else if (state == RS_RECOVER && rtx_cnt == '0) begin
      // Full and empty settle at the end of recovery
      next_flags.full_flag_n  = (count != CW'(DEPTH));
      next_flags.empty_flag_n = (count != '0);
    end
    if (!sync_sel) begin
      next_flags.almost_empty_flag_n = !ae_hit(next_count, ae_offset);
      next_flags.almost_full_flag_n  = !af_hit(next_count, af_offset);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags <= '{full_flag_n: 1'b1, empty_flag_n: 1'b0,
                 almost_full_flag_n: 1'b1, almost_empty_flag_n: 1'b0};
    end else if (ce) begin
      flags <= next_flags;
    end
  end

  // ****************************************
  // Data outputs
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else if (ce) begin
      data_oe <= !s_rd.oe_n;
      if (do_rd) begin
        data_out <= rd_word;
      end
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  assign bus_wr    = avs_write && !avs_waitrequest;
  assign word_addr = {avs_address[4:2], 2'b00};
  assign wr_merged = be_merge(next_rdata, avs_writedata, avs_byteenable);
  assign wr_lanes  = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (word_addr)
      REG_CTRL:       next_rdata[CTRL_SYNC_BIT] = sync_sel;
      REG_AE_OFFSET:  next_rdata[OFFSET_W-1:0] = ae_offset;
      REG_AF_OFFSET:  next_rdata[OFFSET_W-1:0] = af_offset;
      REG_STATUS: begin
        next_rdata[ST_FULL_BIT]  = flags.full_flag_n;
        next_rdata[ST_EMPTY_BIT] = flags.empty_flag_n;
        next_rdata[ST_AF_BIT]    = flags.almost_full_flag_n;
        next_rdata[ST_AE_BIT]    = flags.almost_empty_flag_n;
        next_rdata[ST_RECOV_BIT] = !run;
      end
      REG_COUNT:      next_rdata[CW-1:0] = count;
      REG_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      REG_IRQ_MASK:   next_rdata[IRQ_W-1:0] = irq_mask;
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_sel  <= CTRL_RST[CTRL_SYNC_BIT];
      ae_offset <= AE_OFFSET_RST;
      af_offset <= AF_OFFSET_RST;
      irq_mask  <= '0;
    end else if (ce && bus_wr) begin
      case (word_addr)
        REG_CTRL:      sync_sel  <= wr_merged[CTRL_SYNC_BIT];
        REG_AE_OFFSET: ae_offset <= wr_merged[OFFSET_W-1:0];
        REG_AF_OFFSET: af_offset <= wr_merged[OFFSET_W-1:0];
        REG_IRQ_MASK:  irq_mask  <= wr_merged[IRQ_W-1:0];
        default:       irq_mask <= irq_mask;
      endcase
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_FULL_BIT]  = flags.full_flag_n & ~next_flags.full_flag_n;
    irq_set[IRQ_EMPTY_BIT] = flags.empty_flag_n & ~next_flags.empty_flag_n;
    irq_set[IRQ_AF_BIT]    = flags.almost_full_flag_n & ~next_flags.almost_full_flag_n;
    irq_set[IRQ_AE_BIT]    = flags.almost_empty_flag_n & ~next_flags.almost_empty_flag_n;
    irq_set[IRQ_OVF_BIT]   = wr_try & ~flags.full_flag_n;
    irq_set[IRQ_UNF_BIT]   = rd_try & ~flags.empty_flag_n;
    irq_clr                = '0;
    if (bus_wr && word_addr == REG_IRQ_STATUS) begin
      irq_clr = wr_lanes[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else if (ce) begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      irq        <= |(irq_status & irq_mask);
    end
  end

endmodule // dcf_fifo_core

/* verification/dcf_fifo_chk.sv */
/*
  Checker of the dual-clock FIFO flag block, bound to its top module.
  Assumes a single core clock domain and the link pins driven by agents.
*/
`timescale 1ns/10ps
module dcf_fifo_chk (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst,
  // Register bus
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic                       avs_waitrequest,
  // FIFO pins
  input wire dcf_pkg::dcf_wr_pins_t      wr_pins,
  input wire dcf_pkg::dcf_rd_pins_t      rd_pins,
  input wire logic [dcf_pkg::DATA_W-1:0] data_out,
  input wire logic                       data_oe,
  input wire dcf_pkg::dcf_flags_t        flags,
  input wire logic                       irq
);
  import dcf_pkg::*;
  // ****************************************
  // Cycles since each link clock rose
  // ****************************************
  logic       w_last, r_last;
  logic [3:0] w_age, r_age;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_last <= 1'b0;
      r_last <= 1'b0;
      w_age  <= 4'hF;
      r_age  <= 4'hF;
    end else begin
      w_last <= wr_pins.wclk;
      r_last <= rd_pins.rclk;
      w_age  <= (wr_pins.wclk && !w_last) ? 4'h0 : w_age + 4'(w_age != 4'hF);
      r_age  <= (rd_pins.rclk && !r_last) ? 4'h0 : r_age + 4'(r_age != 4'hF);
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_oe_quiet;
    $stable(rd_pins.oe_n) [*4];
  endsequence
  chk_reset_vals:
    assert property ($fell(rst) |-> flags == 4'b1010 && data_out == '0 && avs_waitrequest && !irq)
    else $error("Wrong values after reset");
  chk_oe_track:
    assert property (s_oe_quiet |-> data_oe == !rd_pins.oe_n)
    else $error("Output enable not followed");
  chk_bus_answer:
    assert property (s_req |=> !avs_waitrequest)
    else $error("Bus answer late");
  chk_bus_pulse:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Bus answer too long");
  chk_bus_cause:
    assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("Bus answer without request");
  chk_full_set:
    assert property ($fell(flags.full_flag_n) |-> w_age <= 4'h6)
    else $error("Full set without write edge");
  chk_full_free:
    assert property ($rose(flags.full_flag_n) |-> r_age <= 4'h6 || w_age <= 4'h6)
    else $error("Full released without edge");
  chk_empty_free:
    assert property ($rose(flags.empty_flag_n) |-> r_age <= 4'h6)
    else $error("Empty released without read edge");
  chk_empty_set:
    assert property ($fell(flags.empty_flag_n) |-> r_age <= 4'h6)
    else $error("Empty set without read edge");
  chk_dout_move:
    assert property ($changed(data_out) |-> r_age <= 4'h6)
    else $error("Data out moved without read edge");
  chk_flag_excl:
    assert property (!(!flags.full_flag_n && !flags.empty_flag_n))
    else $error("Full and empty together");
endmodule // dcf_fifo_chk

bind dcf_fifo_core dcf_fifo_chk u_chk (
  .core_clk(core_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .wr_pins(wr_pins), .rd_pins(rd_pins),
  .data_out(data_out), .data_oe(data_oe), .flags(flags), .irq(irq));

/* verification/dcf_link_agent.sv */
/*
  Writing and reading agents on the FIFO pins, link clocks made per transfer.
  Assumes calls start right after a core clock edge.
*/
`timescale 1ns/10ps
module dcf_link_agent (
  // Clock
  input wire logic              core_clk,
  // Pins
  output dcf_pkg::dcf_wr_pins_t wp,
  output dcf_pkg::dcf_rd_pins_t rp
);
  import dcf_pkg::*;
  initial begin
    wp = '{wclk: 1'b0, wen_n: 1'b1, data: 18'h0_0000};
    rp = '{rclk: 1'b0, ren_n: 1'b1, oe_n: 1'b0, retransmit_n: 1'b1};
    // One clock pulse on each side while reset is held
    @(posedge core_clk);
    wp.wclk <= 1'b1;
    rp.rclk <= 1'b1;
    @(posedge core_clk);
    wp.wclk <= 1'b0;
    rp.rclk <= 1'b0;
  end
  // One write clock period, 12 core cycles, data held around the edge
  task automatic wr(input logic en, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    wp.wen_n <= !en;
    wp.data  <= d;
    repeat (3) @(posedge core_clk);
    wp.wclk <= 1'b1;
    repeat (4) @(posedge core_clk);
    wp.wclk <= 1'b0;
    repeat (4) @(posedge core_clk);
    wp.wen_n <= 1'b1;
    wp.data  <= ~d;
  endtask
  // One read clock period
  task automatic rd(input logic en);
    @(posedge core_clk);
    rp.ren_n <= !en;
    repeat (3) @(posedge core_clk);
    rp.rclk <= 1'b1;
    repeat (4) @(posedge core_clk);
    rp.rclk <= 1'b0;
    repeat (4) @(posedge core_clk);
    rp.ren_n <= 1'b1;
  endtask
  task automatic rtx();
    @(posedge core_clk);
    rp.retransmit_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rp.retransmit_n <= 1'b1;
  endtask
  task automatic set_oe(input logic v);
    @(posedge core_clk);
    rp.oe_n <= v;
  endtask
endmodule // dcf_link_agent

/* verification/tb.sv */
/*
  Self-checking bench of the dual-clock FIFO flag block, depth cut to 16.
  Assumes the link agent and the bound checker beside the design.
*/
`timescale 1ns/10ps
module tb;
  import dcf_pkg::*;
  localparam int D = 16;
  localparam int N = 2;
  localparam int M = 3;
  logic                core_clk, rst, ce, avs_read, avs_write, avs_waitrequest;
  logic [4:0]          avs_address;
  logic [31:0]         avs_writedata, avs_readdata;
  logic [3:0]          avs_byteenable;
  logic [DATA_W-1:0]   data_out;
  logic                data_oe, irq;
  dcf_wr_pins_t        wr_pins;
  dcf_rd_pins_t        rd_pins;
  dcf_flags_t          flags;
  int                  fail_count, n_compared;

  dcf_fifo_core #(.DEPTH(D)) DUT (
    .core_clk(core_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wr_pins(wr_pins), .rd_pins(rd_pins),
    .data_out(data_out), .data_oe(data_oe), .flags(flags), .irq(irq));
  dcf_link_agent ag (.core_clk(core_clk), .wp(wr_pins), .rp(rd_pins));

  always #(CORE_CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic ckf(input logic [3:0] e);
    ck(32'(flags), 32'(e));
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    ck(32'(n), 32'h0000_0002);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    ck(q, e);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  function automatic logic [17:0] wd(input int i);
    return 18'h2_A000 + 18'(i);
  endfunction
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    ckf({2'b10, 32'(AF_OFFSET_RST) + 1 < D, 1'b0});
    ck(32'(data_out), 32'h0000_0000);
    ck(32'(data_oe), 32'h0000_0001);
    ag.set_oe(1'b1);
    repeat (4) @(posedge core_clk);
    ck(32'(data_oe), 32'h0000_0000);
    ag.set_oe(1'b0);
  endtask
  task automatic t_regs;
    rc(REG_CTRL, CTRL_RST);
    rc(REG_AE_OFFSET, 32'(AE_OFFSET_RST));
    rc(REG_AF_OFFSET, 32'(AF_OFFSET_RST));
    rc(REG_STATUS, {29'h0000_0000, 32'(AF_OFFSET_RST) + 1 < D, 2'b01});
    wreg(5'h1C, 32'hFFFF_FFFF);
    rc(5'h1C, 32'h0000_0000);
    avs_byteenable <= 4'h1;
    wreg(REG_AE_OFFSET, 32'hFFFF_FF00 | 32'(N));
    avs_byteenable <= 4'hF;
    wreg(REG_AF_OFFSET, 32'(M));
    wreg(REG_IRQ_MASK, 32'h0000_0000);
    rc(REG_AF_OFFSET, 32'(M));
  endtask
  task automatic t_fill;
    for (int i = 1; i <= D; i++) begin
      ag.wr(1'b1, wd(i));
      if (i == 1) begin
        ckf(4'b1010);
        ag.rd(1'b0);
      end
      ckf({i < D, 1'b1, i + M + 1 < D, i >= N});
    end
    ag.wr(1'b1, 18'h3_FFFF);
    ckf(4'b0101);
    rc(REG_COUNT, 32'(D));
    ck(32'(irq), 32'h0000_0000);
    wreg(REG_IRQ_MASK, 32'h0000_0010);
    repeat (2) @(posedge core_clk);
    ck(32'(irq), 32'h0000_0001);
    wreg(REG_IRQ_STATUS, 32'h0000_0010);
    repeat (2) @(posedge core_clk);
    ck(32'(irq), 32'h0000_0000);
  endtask
  task automatic t_drain;
    logic [31:0] q;
    for (int i = 1; i <= D; i++) begin
      ag.rd(1'b1);
      ck(32'(data_out), 32'(wd(i)));
      if (i == 1) ag.wr(1'b0, 18'h0_0000);
      ckf({1'b1, i < D, i > M + 1, i <= D - N});
    end
    ag.rd(1'b1);
    ck(32'(data_out), 32'(wd(D)));
    bus(1'b0, REG_IRQ_STATUS, 32'h0000_0000, q);
    ck(q & 32'h0000_0030, 32'h0000_0020);
  endtask
  task automatic t_retx;
    for (int i = 1; i <= 3; i++) ag.wr(1'b1, wd(D + i));
    ag.rd(1'b0);
    ag.rd(1'b1);
    ck(32'(data_out), 32'(wd(D + 1)));
    ag.rtx();
    repeat (12) @(posedge core_clk);
    rc(REG_STATUS, 32'h0000_000F);
    for (int i = 1; i <= 3; i++) begin
      ag.rd(1'b1);
      ck(32'(data_out), 32'(wd(D + i)));
    end
    ckf(4'b1010);
  endtask
  task automatic t_sync;
    wreg(REG_CTRL, 32'h0000_0001);
    for (int i = 1; i <= 2; i++) ag.wr(1'b1, wd(i));
    fork
      ag.wr(1'b1, wd(3));
      ag.rd(1'b0);
    join
    ckf(4'b1010);
    ag.rd(1'b0);
    ckf(4'b1111);
    ce <= 1'b0;
    ag.wr(1'b1, wd(4));
    ce <= 1'b1;
    rc(REG_COUNT, 32'h0000_0003);
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    t_reset;
    t_regs;
    t_fill;
    t_drain;
    t_retx;
    t_sync;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    wrap_up;
  end
endmodule // tb
